// File: rtl/pscg_regs.svh
// register offsets, field positions, reset values and frame counts of the pll status and control bank
`ifndef PSCG_REGS_SVH
`define PSCG_REGS_SVH
`define PSCG_ADDR_IRQ_EN 7'h69
`define PSCG_ADDR_LATCHED 7'h6E
`define PSCG_ADDR_STATUS 7'h6F
`define PSCG_ADDR_DIV_INIT 7'h71
`define PSCG_ADDR_SYNTH_LOCK_RESTART 7'h72
`define PSCG_ADDR_BIAS_EDGE 7'h73
`define PSCG_BIT_CMD 7
`define PSCG_BIT_EDGE_SEL 0
`define PSCG_BIT_REF_CHANGE_IRQ_EN 1
`define PSCG_BIT_HOLDOVER_IRQ_EN 0
`define PSCG_BIT_REF_VALID_LATCHED 1
`define PSCG_BIT_LS_HOLD 0
`define PSCG_BIT_ST_CAL 2
`define PSCG_BIT_REF_PRESENT_NOW 1
`define PSCG_BIT_ST_HOLD 0
`define PSCG_RST_EDGE_SEL 1'b0
`define PSCG_RST_IE 1'b0
`define PSCG_RST_LATCHED 1'b1
`define PSCG_RST_PEND 1'b0
`define PSCG_RST_SYNC_IN 5'h03
`define PSCG_CMD_LAST 5'h07
`define PSCG_RD_FIRST 5'h08
`define PSCG_FRAME_LAST 5'h0F
`define PSCG_FRAME_BITS 5'h10
`endif

// File: rtl/pscg_pkg.sv
// types shared by the pll status and control bank
package pscg_pkg;
  typedef enum logic {
    PSCG_ACC_WRITE = 1'b0,
    PSCG_ACC_READ = 1'b1
  } pscg_acc_t;
endpackage

// File: rtl/pscg_sync.sv
// three-stage synchroniser with agreement filter, one lane per bit
`timescale 1ns/1ps
module pscg_sync
  import pscg_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_lane
      logic s1_q;
      logic s2_q;
      logic s3_q;
      always_ff @(posedge clk) begin
        if (!resetn) begin
          s1_q <= RST[i];
          s2_q <= RST[i];
          s3_q <= RST[i];
        end else begin
          s1_q <= d[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end
      // a change only counts once the last two stages agree
      always_ff @(posedge clk) begin
        if (!resetn) begin
          q[i] <= RST[i];
        end else if (s2_q == s3_q) begin
          q[i] <= s3_q;
        end
      end
    end
  endgenerate
endmodule

// File: rtl/pscg_top.sv
// pll status latches, command bits and serial register port
`timescale 1ns/1ps
`include "pscg_regs.svh"
module pscg_top
  import pscg_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic three_wire_serial_io_in,
  output logic three_wire_serial_io_out,
  output logic three_wire_serial_io_oe_n,
  input wire logic ref_present_in,
  input wire logic holdover_free_in,
  input wire logic synth_cal_in,
  input wire logic bias_cal_done_in,
  output logic divider_init_pulse,
  output logic synth_lock_restart,
  output logic bias_cal_start,
  output logic irq_out_n
);
  // ---------------- serial clock domain ----------------
  logic [4:0] cnt_q;
  logic [15:0] sr_q;
  pscg_acc_t acc_q;
  logic [7:0] rd_byte_q;
  logic [7:0] rd_byte_d;
  logic out_p_q;
  logic out_n_q;
  logic oe_n_q;
  logic wr_tog_q;
  logic [6:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic [6:0] cmd_addr;
  logic [7:0] rb_vec;
  logic [7:0] rb_s;

  // ---------------- system clock domain ----------------
  logic [4:0] cin_s;
  logic ref_present_now;
  logic holdover_free_now;
  logic synth_cal_active;
  logic bias_done_s;
  logic tog_seen_q;
  logic done_prev_q;
  logic wr_stb;
  logic ref_change_irq_en;
  logic holdover_irq_en;
  logic ref_valid_latched;
  logic holdover_free_latched;
  logic ref_pend_q;
  logic hold_pend_q;
  logic read_edge_select;
  logic div_init_q;
  logic synth_lock_restart_q;
  logic bias_q;
  logic irq_n_q;
  logic clr_ref;
  logic clr_hold;
  logic ref_loss;
  logic hold_entry;
  logic done_rise;

  // frame: rw bit, 7 address bits, 8 data bits, msb first, sampled on rising sclk
  assign cmd_addr = {sr_q[5:0], three_wire_serial_io_in};

  // chip select idle clears the frame position; sclk may stop between frames
  always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      cnt_q <= 5'h00;
      sr_q <= 16'h0000;
    end else begin
      sr_q <= {sr_q[14:0], three_wire_serial_io_in};
      if (cnt_q != `PSCG_FRAME_BITS) begin
        cnt_q <= 5'(cnt_q + 5'h01);
      end
    end
  end

  always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      acc_q <= PSCG_ACC_WRITE;
      rd_byte_q <= 8'h00;
    end else if (cnt_q == `PSCG_CMD_LAST) begin
      acc_q <= pscg_acc_t'(sr_q[6]);
      rd_byte_q <= rd_byte_d;
    end
  end

  // readback bits arrive synchronised; eight command edges give them time to settle
  always_comb begin
    rd_byte_d = 8'h00;
    if (cmd_addr == `PSCG_ADDR_IRQ_EN) begin
      rd_byte_d = {6'h00, rb_s[6], rb_s[5]};
    end else if (cmd_addr == `PSCG_ADDR_LATCHED) begin
      rd_byte_d = {6'h00, rb_s[4], rb_s[3]};
    end else if (cmd_addr == `PSCG_ADDR_STATUS) begin
      rd_byte_d = {5'h00, rb_s[2], rb_s[1], rb_s[0]};
    end else if (cmd_addr == `PSCG_ADDR_BIAS_EDGE) begin
      rd_byte_d = {7'h00, rb_s[7]};
    end else begin
      rd_byte_d = 8'h00;
    end
  end

  // rising-edge launch of read data
  always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      out_p_q <= 1'b0;
    end else if (acc_q == PSCG_ACC_READ && cnt_q >= `PSCG_RD_FIRST && cnt_q <= `PSCG_FRAME_LAST) begin
      out_p_q <= rd_byte_q[~cnt_q[2:0]];
    end
  end

  // falling-edge launch of read data
  always_ff @(negedge spi_sclk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      out_n_q <= 1'b0;
    end else if (acc_q == PSCG_ACC_READ && cnt_q >= `PSCG_RD_FIRST && cnt_q <= `PSCG_FRAME_LAST) begin
      out_n_q <= rd_byte_q[~cnt_q[2:0]];
    end
  end

  // turnaround on a falling edge so the host has released the wire
  always_ff @(negedge spi_sclk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      oe_n_q <= 1'b1;
    end else if (acc_q == PSCG_ACC_READ && cnt_q >= `PSCG_RD_FIRST) begin
      oe_n_q <= 1'b0;
    end
  end

  // write word held stable until the next complete write frame
  always_ff @(posedge spi_sclk or negedge resetn) begin
    if (!resetn) begin
      wr_tog_q <= 1'b0;
      wr_addr_q <= 7'h00;
      wr_data_q <= 8'h00;
    end else if (cnt_q == `PSCG_FRAME_LAST && acc_q == PSCG_ACC_WRITE) begin
      wr_tog_q <= ~wr_tog_q;
      wr_addr_q <= sr_q[13:7];
      wr_data_q <= {sr_q[6:0], three_wire_serial_io_in};
    end
  end

  // two flops with different edges; the select itself settles before data leaves
  assign three_wire_serial_io_out = rb_s[7] ? out_p_q : out_n_q;
  assign three_wire_serial_io_oe_n = oe_n_q;

  pscg_sync #(.W(8), .RST(8'h00)) u_rb_sync (
    .clk(spi_sclk),
    .resetn(1'b1),
    .d(rb_vec),
    .q(rb_s)
  );

  // ---------------- system clock side ----------------
  pscg_sync #(.W(5), .RST(`PSCG_RST_SYNC_IN)) u_in_sync (
    .clk(clk),
    .resetn(resetn),
    .d({wr_tog_q, bias_cal_done_in, synth_cal_in, holdover_free_in, ref_present_in}),
    .q(cin_s)
  );

  assign ref_present_now = cin_s[0];
  assign holdover_free_now = cin_s[1];
  assign synth_cal_active = cin_s[2];
  assign bias_done_s = cin_s[3];
  assign wr_stb = cin_s[4] ^ tog_seen_q;
  assign done_rise = bias_done_s & ~done_prev_q;
  assign ref_loss = ~ref_present_now;
  assign hold_entry = ~holdover_free_now;
  assign clr_ref = wr_stb && wr_addr_q == `PSCG_ADDR_LATCHED && wr_data_q[`PSCG_BIT_REF_VALID_LATCHED];
  assign clr_hold = wr_stb && wr_addr_q == `PSCG_ADDR_LATCHED && wr_data_q[`PSCG_BIT_LS_HOLD];

  assign rb_vec = {read_edge_select, ref_change_irq_en, holdover_irq_en, ref_valid_latched,
                   holdover_free_latched, synth_cal_active, ref_present_now, holdover_free_now};

  always_ff @(posedge clk) begin
    if (!resetn) begin
      tog_seen_q <= 1'b0;
      done_prev_q <= 1'b0;
    end else begin
      tog_seen_q <= cin_s[4];
      done_prev_q <= bias_done_s;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ref_change_irq_en <= `PSCG_RST_IE;
      holdover_irq_en <= `PSCG_RST_IE;
    end else if (wr_stb && wr_addr_q == `PSCG_ADDR_IRQ_EN) begin
      ref_change_irq_en <= wr_data_q[`PSCG_BIT_REF_CHANGE_IRQ_EN];
      holdover_irq_en <= wr_data_q[`PSCG_BIT_HOLDOVER_IRQ_EN];
    end
  end

  // loss beats a clear in the same cycle, so no event is missed
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ref_valid_latched <= `PSCG_RST_LATCHED;
    end else if (ref_loss) begin
      ref_valid_latched <= 1'b0;
    end else if (clr_ref) begin
      ref_valid_latched <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      holdover_free_latched <= `PSCG_RST_LATCHED;
    end else if (hold_entry) begin
      holdover_free_latched <= 1'b0;
    end else if (clr_hold) begin
      holdover_free_latched <= 1'b1;
    end
  end

  // pending flags: the only hardware change of a latch is toward 0
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ref_pend_q <= `PSCG_RST_PEND;
    end else if (ref_loss && (ref_valid_latched || clr_ref)) begin
      ref_pend_q <= 1'b1;
    end else if (clr_ref) begin
      ref_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      hold_pend_q <= `PSCG_RST_PEND;
    end else if (hold_entry && (holdover_free_latched || clr_hold)) begin
      hold_pend_q <= 1'b1;
    end else if (clr_hold) begin
      hold_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= ~((ref_change_irq_en & ref_pend_q) | (holdover_irq_en & hold_pend_q));
    end
  end

  // one-cycle command strobes; writing 0 leaves them idle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      div_init_q <= 1'b0;
      synth_lock_restart_q <= 1'b0;
    end else begin
      div_init_q <= wr_stb && wr_addr_q == `PSCG_ADDR_DIV_INIT && wr_data_q[`PSCG_BIT_CMD];
      synth_lock_restart_q <= wr_stb && wr_addr_q == `PSCG_ADDR_SYNTH_LOCK_RESTART && wr_data_q[`PSCG_BIT_CMD];
    end
  end

  // bias calibration request held until the done input rises; a new start wins
  always_ff @(posedge clk) begin
    if (!resetn) begin
      bias_q <= 1'b0;
    end else if (wr_stb && wr_addr_q == `PSCG_ADDR_BIAS_EDGE && wr_data_q[`PSCG_BIT_CMD]) begin
      bias_q <= 1'b1;
    end else if (done_rise) begin
      bias_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      read_edge_select <= `PSCG_RST_EDGE_SEL;
    end else if (wr_stb && wr_addr_q == `PSCG_ADDR_BIAS_EDGE) begin
      read_edge_select <= wr_data_q[`PSCG_BIT_EDGE_SEL];
    end
  end

  assign divider_init_pulse = div_init_q;
  assign synth_lock_restart = synth_lock_restart_q;
  assign bias_cal_start = bias_q;
  assign irq_out_n = irq_n_q;

  // ---------------- checks ----------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_div_cmd;
    wr_stb && wr_addr_q == `PSCG_ADDR_DIV_INIT && wr_data_q[`PSCG_BIT_CMD];
  endsequence
  sequence s_one_pulse_div;
    divider_init_pulse ##1 !divider_init_pulse;
  endsequence
  sequence s_synth_lock_restart_cmd;
    wr_stb && wr_addr_q == `PSCG_ADDR_SYNTH_LOCK_RESTART && wr_data_q[`PSCG_BIT_CMD];
  endsequence
  sequence s_bias_cmd;
    wr_stb && wr_addr_q == `PSCG_ADDR_BIAS_EDGE && wr_data_q[`PSCG_BIT_CMD];
  endsequence

  a_ref_loss_latch: assert property (ref_loss |=> !ref_valid_latched)
    else $error("reference latch missed a loss");
  a_ref_latch_rise: assert property ($rose(ref_valid_latched) |-> $past(clr_ref) && !$past(ref_loss))
    else $error("reference latch set without a clear");
  a_ref_clear_irq: assert property (clr_ref && !ref_loss |=> ref_valid_latched && !ref_pend_q
                                    ##1 (irq_out_n || $past(holdover_irq_en && hold_pend_q)))
    else $error("reference clear did not cancel interrupt");
  a_hold_latch: assert property (hold_entry |=> !holdover_free_latched)
    else $error("holdover latch missed an entry");
  a_hold_rise: assert property ($rose(holdover_free_latched) |-> $past(clr_hold) && !$past(hold_entry))
    else $error("holdover latch set without a clear");
  a_hold_clear: assert property (clr_hold && !hold_entry |=> !hold_pend_q)
    else $error("holdover clear did not withdraw pending");
  a_cal_status: assert property (synth_cal_in [*8] |-> synth_cal_active)
    else $error("calibration flag does not follow input");
  a_ref_status: assert property (!ref_present_in [*8] |-> !ref_present_now)
    else $error("reference status does not follow input");
  a_hold_status: assert property (!holdover_free_in [*8] |-> !holdover_free_now)
    else $error("holdover status does not follow input");
  a_div_pulse: assert property (s_div_cmd |=> s_one_pulse_div)
    else $error("divider init not a single pulse");
  a_div_cause: assert property ($rose(divider_init_pulse) |-> $past(wr_stb) && $past(wr_data_q[7]))
    else $error("divider init without a write of 1");
  a_synth_lock_restart_pulse: assert property (s_synth_lock_restart_cmd |=> synth_lock_restart ##1 !synth_lock_restart)
    else $error("synth_lock_restart not a single pulse");
  a_bias_start: assert property (s_bias_cmd |=> bias_cal_start)
    else $error("bias calibration not started");
  a_bias_clear: assert property (done_rise && !(wr_stb && wr_addr_q == `PSCG_ADDR_BIAS_EDGE && wr_data_q[`PSCG_BIT_CMD])
                                 |=> !bias_cal_start)
    else $error("bias calibration command did not clear");
  a_bias_hold: assert property ($fell(bias_cal_start) |-> $past(done_rise))
    else $error("bias command dropped before done");
  a_edge_reset: assert property (@(posedge clk) disable iff (1'b0)
                                 !resetn |=> !read_edge_select)
    else $error("edge select not zero after reset");
  a_irq_ref: assert property (ref_change_irq_en && ref_pend_q |=> !irq_out_n)
    else $error("reference interrupt not raised");
  a_irq_hold: assert property (hold_entry && holdover_free_latched && holdover_irq_en |=> ##1 !irq_out_n)
    else $error("holdover interrupt not raised");
  a_irq_quiet: assert property (!ref_pend_q && !hold_pend_q |=> irq_out_n)
    else $error("interrupt without a pending flag");
  a_read_drive: assert property (@(negedge spi_sclk) disable iff (spi_cs_n)
                                 cnt_q == 5'h09 && acc_q == PSCG_ACC_READ |-> !three_wire_serial_io_oe_n)
    else $error("read data not driven");
endmodule

// File: verification/pscg_spi_host.sv
// serial host model driving the register port of the status and control bank
`timescale 1ns/1ps
module pscg_spi_host (
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic sdio_to_dut,
  input wire logic sdio_from_dut,
  input wire logic sdio_oe_n
);
  logic drv_en;
  logic drv_val;
  // pull-up on the shared data line, so a released line reads 1
  assign sdio_to_dut = drv_en ? drv_val : (sdio_oe_n ? 1'b1 : sdio_from_dut);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b0;
    drv_en = 1'b0;
    drv_val = 1'b1;
    // deselect after time zero, so the frame logic sees a real rising edge
    #1 spi_cs_n = 1'b1;
  end
  // one 16-bit frame; the serial clock stands low outside frames
  task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] wdat, input logic sel,
                      output logic [7:0] rdat);
    logic [15:0] word;
    word = {rd, addr, wdat};
    rdat = 8'h00;
    spi_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      drv_en = !(rd && i < 8);
      drv_val = word[i];
      #7.5 spi_sclk = 1'b1;
      if (rd && i < 8 && !sel) rdat[i] = sdio_to_dut;
      #7.5 spi_sclk = 1'b0;
      if (rd && i < 8 && sel) rdat[i] = sdio_to_dut;
    end
    #7.5 spi_cs_n = 1'b1;
    drv_en = 1'b0;
    #15;
  endtask
endmodule

// File: verification/tb_pll_status_and_general_control.sv
// self-checking testbench of the pll status and control bank
`timescale 1ns/1ps
`include "pscg_regs.svh"
module tb_pll_status_and_general_control;
  import pscg_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b1;
  logic ref_in = 1'b1;
  logic hold_in = 1'b1;
  logic cal_in = 1'b0;
  logic done_in = 1'b0;
  wire logic sclk;
  wire logic cs_n;
  wire logic sdi;
  logic sdo;
  logic oe_n;
  logic div_p;
  logic synth_lock_restart_p;
  logic bias_s;
  logic irq_n;
  int error_cnt = 0;
  int n_tests = 0;
  int n_div = 0;
  int n_rel = 0;
  logic [7:0] rd;
  logic [7:0] x;
  logic [1:0] exp_lat;
  logic r;
  logic h;
  logic c;

  always #2 clk = ~clk;

  pscg_top u_dut (
    .clk(clk), .resetn(resetn), .spi_sclk(sclk), .spi_cs_n(cs_n),
    .three_wire_serial_io_in(sdi), .three_wire_serial_io_out(sdo), .three_wire_serial_io_oe_n(oe_n),
    .ref_present_in(ref_in), .holdover_free_in(hold_in), .synth_cal_in(cal_in),
    .bias_cal_done_in(done_in), .divider_init_pulse(div_p), .synth_lock_restart(synth_lock_restart_p),
    .bias_cal_start(bias_s), .irq_out_n(irq_n)
  );

  pscg_spi_host u_host (
    .spi_sclk(sclk), .spi_cs_n(cs_n), .sdio_to_dut(sdi), .sdio_from_dut(sdo), .sdio_oe_n(oe_n)
  );

  // counting high cycles shows a stretched pulse as an extra count
  always @(posedge clk) begin
    if (div_p === 1'b1) n_div <= n_div + 1;
    if (synth_lock_restart_p === 1'b1) n_rel <= n_rel + 1;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp, input string what);
    chk({7'h00, got}, {7'h00, exp}, what);
  endtask

  // pulse counts stay far below 256
  task automatic chk_cnt(input int got, input int exp, input string what);
    chk(8'(got), 8'(exp), what);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] junk;
    u_host.xfer(1'b0, a, d, 1'b0, junk);
    repeat (12) @(posedge clk);
  endtask

  task automatic rdr(input logic [6:0] a, input logic sel, output logic [7:0] d);
    u_host.xfer(1'b1, a, 8'h00, sel, d);
  endtask

  // status inputs pass a synchroniser, so let them settle before looking
  task automatic setin(input logic rv, input logic hv, input logic cv);
    @(posedge clk);
    ref_in <= rv;
    hold_in <= hv;
    cal_in <= cv;
    repeat (10) @(posedge clk);
  endtask

  function automatic logic [7:0] stat_exp(input logic cv, input logic rv, input logic hv);
    return {5'h00, cv, rv, hv};
  endfunction

  task automatic wrap_up();
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    #100000;
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end

  initial begin
    // a real falling edge, so the write holding flops clear as well
    resetn <= 1'b0;
    void'($urandom(32'h487C739F));
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    chk_pin(irq_n, 1'b1, "irq idle");
    rdr(`PSCG_ADDR_BIAS_EDGE, 1'b0, rd);
    chk(rd, 8'h00, "edge select reset");
    rdr(`PSCG_ADDR_LATCHED, 1'b0, rd);
    chk(rd, 8'h03, "latches reset");
    rdr(`PSCG_ADDR_STATUS, 1'b0, rd);
    chk(rd, stat_exp(1'b0, 1'b1, 1'b1), "status reset");
    wr(`PSCG_ADDR_DIV_INIT, 8'h80);
    chk_cnt(n_div, 1, "divider init pulse");
    wr(`PSCG_ADDR_DIV_INIT, 8'h00);
    chk_cnt(n_div, 1, "divider init zero write");
    wr(`PSCG_ADDR_SYNTH_LOCK_RESTART, 8'h80);
    chk_cnt(n_rel, 1, "synth_lock_restart pulse");
    wr(`PSCG_ADDR_SYNTH_LOCK_RESTART, 8'h7F);
    chk_cnt(n_rel, 1, "synth_lock_restart zero write");
    rdr(`PSCG_ADDR_SYNTH_LOCK_RESTART, 1'b0, rd);
    chk(rd, 8'h00, "command reads zero");
    wr(`PSCG_ADDR_BIAS_EDGE, 8'h80);
    chk_pin(bias_s, 1'b1, "bias start");
    repeat (20) @(posedge clk);
    chk_pin(bias_s, 1'b1, "bias held");
    done_in <= 1'b1;
    repeat (10) @(posedge clk);
    chk_pin(bias_s, 1'b0, "bias ends on done");
    done_in <= 1'b0;
    wr(7'h10, 8'hFF);
    rdr(7'h10, 1'b0, rd);
    chk(rd, 8'h00, "unmapped reads zero");
    for (int i = 0; i < 3; i++) begin
      x = 8'($urandom);
      wr(`PSCG_ADDR_IRQ_EN, x);
      rdr(`PSCG_ADDR_IRQ_EN, 1'b0, rd);
      chk(rd, x & 8'h03, "enable readback");
    end
    wr(`PSCG_ADDR_IRQ_EN, 8'h00);
    exp_lat = 2'b11;
    for (int i = 0; i < 8; i++) begin
      r = 1'($urandom);
      h = 1'($urandom);
      c = 1'($urandom);
      setin(r, h, c);
      exp_lat = exp_lat & {r, h};
      rdr(`PSCG_ADDR_STATUS, 1'b0, rd);
      chk(rd, stat_exp(c, r, h), "momentary status");
      rdr(`PSCG_ADDR_LATCHED, 1'b0, rd);
      chk(rd, {6'h00, exp_lat}, "latched status");
    end
    setin(1'b1, 1'b1, 1'b0);
    wr(`PSCG_ADDR_LATCHED, 8'h03);
    rdr(`PSCG_ADDR_LATCHED, 1'b0, rd);
    chk(rd, 8'h03, "latches cleared");
    wr(`PSCG_ADDR_BIAS_EDGE, 8'h01);
    rdr(`PSCG_ADDR_BIAS_EDGE, 1'b1, rd);
    chk(rd, 8'h01, "rising edge readback");
    rdr(`PSCG_ADDR_LATCHED, 1'b1, rd);
    chk(rd, 8'h03, "rising edge latches");
    wr(`PSCG_ADDR_BIAS_EDGE, 8'h00);
    wr(`PSCG_ADDR_IRQ_EN, 8'h02);
    setin(1'b0, 1'b1, 1'b0);
    chk_pin(irq_n, 1'b0, "ref loss irq");
    wr(`PSCG_ADDR_LATCHED, 8'h02);
    rdr(`PSCG_ADDR_LATCHED, 1'b0, rd);
    chk(rd, 8'h01, "clear loses to loss");
    chk_pin(irq_n, 1'b0, "irq kept");
    setin(1'b1, 1'b1, 1'b0);
    wr(`PSCG_ADDR_LATCHED, 8'h02);
    chk_pin(irq_n, 1'b1, "ref irq cleared");
    wr(`PSCG_ADDR_IRQ_EN, 8'h01);
    setin(1'b1, 1'b0, 1'b0);
    chk_pin(irq_n, 1'b0, "holdover irq");
    rdr(`PSCG_ADDR_LATCHED, 1'b0, rd);
    chk(rd, 8'h02, "holdover latched");
    setin(1'b1, 1'b1, 1'b0);
    wr(`PSCG_ADDR_LATCHED, 8'h01);
    chk_pin(irq_n, 1'b1, "holdover irq cleared");
    rdr(`PSCG_ADDR_LATCHED, 1'b0, rd);
    chk(rd, 8'h03, "holdover latch back");
    wr(`PSCG_ADDR_IRQ_EN, 8'h00);
    setin(1'b0, 1'b1, 1'b0);
    chk_pin(irq_n, 1'b1, "masked ref loss");
    setin(1'b1, 1'b1, 1'b0);
    wr(`PSCG_ADDR_LATCHED, 8'h03);
    wrap_up();
  end
endmodule
